// File: shared/pib_pkg.sv
// constants for the primary interrupt enable and flag bank
// assumes an 8-bit register port with a 4-bit word address
package pib_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // widths and counts
  localparam int DW = 8;
  localparam int AW = 4;
  localparam int NUM_GRP = 7;
  localparam int SUB_W = 4;

  ////////////////////////////////////////////////////////////////////////////
  // register offsets (word index on the register port)
  localparam logic [3:0] OFS_CTRL_A = 4'h0;
  localparam logic [3:0] OFS_CTRL_B = 4'h1;
  localparam logic [3:0] OFS_CTRL_C = 4'h2;
  localparam logic [3:0] OFS_SUB_BASE = 4'h3;
  localparam logic [3:0] OFS_STAT = 4'hA;
  localparam logic [3:0] OFS_MASK = 4'hB;

  ////////////////////////////////////////////////////////////////////////////
  // primary_irq_ctrl_a fields
  localparam int CA_GLOBAL_ALLOW = 0;
  localparam int CA_GRP0_ALLOW = 1;
  localparam int CA_PIN_ALLOW = 2;
  localparam int CA_CMP_ALLOW = 3;
  localparam int CA_GRP0_PEND = 4;
  localparam int CA_PIN_PEND = 5;
  localparam int CA_CMP_PEND = 6;
  // pending bits sit three above their allow bits
  localparam int CA_ALLOW_LSB = 1;
  localparam int CA_PEND_LSB = 4;

  // primary_irq_ctrl_b fields
  localparam int CB_NF_ALLOW = 0;
  localparam int CB_GRP1_ALLOW = 1;
  localparam int CB_LVD_ALLOW = 2;
  localparam int CB_OCP_ALLOW = 3;
  localparam int CB_NF_PEND = 4;
  localparam int CB_GRP1_PEND = 5;
  localparam int CB_LVD_PEND = 6;
  localparam int CB_OCP_PEND = 7;

  // primary_irq_ctrl_c fields
  localparam int CC_GRP2_ALLOW = 0;
  localparam int CC_GRP3_ALLOW = 1;
  localparam int CC_GRP4_ALLOW = 2;
  localparam int CC_GRP5_ALLOW = 3;
  localparam int CC_GRP2_PEND = 4;
  localparam int CC_GRP3_PEND = 5;
  localparam int CC_GRP4_PEND = 6;
  localparam int CC_GRP5_PEND = 7;

  // in b, c and every sub-source register: flags high nibble, allows low
  localparam int PEND_LSB = 4;
  localparam int ALLOW_LSB = 0;

  ////////////////////////////////////////////////////////////////////////////
  // implemented bits, unimplemented ones read as zero
  localparam logic [7:0] CTRL_A_IMPL = 8'h7F;
  localparam logic [7:0] CTRL_B_IMPL = 8'hFF;
  localparam logic [7:0] CTRL_C_IMPL = 8'hFF;
  // index 0 is sub-source register zero
  localparam logic [6:0][7:0] SUB_IMPL = {8'h33, 8'h33, 8'h33, 8'h33, 8'hFF, 8'hFF, 8'h77};

  ////////////////////////////////////////////////////////////////////////////
  // status / mask layout
  localparam int ST_CORE_RISE = 0;
  localparam int ST_PIN_EDGE = 1;
  localparam int ST_OVERRUN = 2;
  localparam logic [7:0] ST_IMPL = 8'h07;

  ////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] SUB_RST = 8'h00;
  localparam logic [7:0] STAT_RST = 8'h00;
  localparam logic [7:0] MASK_RST = 8'h00;

endpackage

// File: shared/pib_grp_if.sv
// carries sub-source flags and allows to the group merger and its requests back
// assumes both ends sit in the same clock domain
`timescale 1ns/1ps
interface pib_grp_if;
  logic [6:0][3:0] subPend;
  logic [6:0][3:0] subAllow;
  logic [6:0] grpReq;

  modport bank (output subPend, output subAllow, input grpReq);
  modport merge (input subPend, input subAllow, output grpReq);
endinterface

// File: hdl/pib_group_merge.sv
// folds each group's sub-source flags into one group request
// assumes flags and allows come straight from registers of the bank
`timescale 1ns/1ps
module pib_group_merge
(
  pib_grp_if.merge grp
);

  ////////////////////////////////////////////////////////////////////////////
  // one request per group: any sub flag with its allow set
  genvar g;
  generate
    for (g = 0; g < 7; g++)
    begin : gMerge
      assign grp.grpReq[g] = |(grp.subPend[g] & grp.subAllow[g]);
    end
  endgenerate

endmodule

// File: hdl/pib_flag_bank.sv
// primary interrupt enable and flag bank with sub-source group registers
// assumes a single 20 MHz clock, synchronous reset, one-cycle event pulses
// from on-chip sources and an asynchronous external interrupt pin
//
// Added by the designer: strobed register access and the register addresses.
`timescale 1ns/1ps

// Functional notes
// - group one pending at ctrl_b bit 5
// - group three pending at ctrl_c bit 5
// - group two pending at ctrl_c bit 4
// - group five allow at ctrl_c bit 3
// - every source but group six has allow and pending bits
// - group flags come from seven sub-source registers
module pib_flag_bank
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdata,
  input wire logic extIntPin,
  input wire logic cmpEvt,
  input wire logic nfEvt,
  input wire logic lvdEvt,
  input wire logic ocpEvt,
  input wire logic [27:0] subEvt,
  output logic coreIrq,
  output logic groupSixReq,
  output logic irqOut
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // address match, shared by write and read decode
  function automatic logic regHit(input logic [3:0] a, input logic [3:0] ofs);
    return a == ofs;
  endfunction

  // software write then hardware set, so a set in the same cycle wins
  function automatic logic [7:0] flagUpd(
    input logic [7:0] cur,
    input logic wrHit,
    input logic [7:0] wdata,
    input logic [7:0] setBits,
    input logic [7:0] impl
  );
    logic [7:0] base;
    base = wrHit ? wdata : cur;
    // unimplemented bits masked last, so neither path can raise them
    return (base | setBits) & impl;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  // software registers and their next values
  logic [7:0] ctrlA_r;
  logic [7:0] ctrlA_nxt;
  logic [7:0] ctrlB_r;
  logic [7:0] ctrlB_nxt;
  logic [7:0] ctrlC_r;
  logic [7:0] ctrlC_nxt;
  logic [6:0][7:0] sub_r;
  logic [6:0][7:0] sub_nxt;
  logic [7:0] stat_r;
  logic [7:0] stat_nxt;
  logic [7:0] mask_r;
  logic [7:0] mask_nxt;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  // synchroniser and output flops
  logic pinMeta_r;
  logic pinSync_r;
  logic pinLast_r;
  logic coreIrq_r;
  logic irqOut_r;
  logic grpSix_r;
  // combinational terms
  logic pinEdge;
  logic coreReq;
  logic reqA;
  logic reqB;
  logic reqC;
  logic [7:0] setA;
  logic [7:0] setB;
  logic [7:0] setC;
  logic overrun;

  pib_grp_if grpBus ();

  ////////////////////////////////////////////////////////////////////////////
  // external pin: two flops, then a rising-edge detect on the synced level
  // edge polarity is fixed here; edge selection lives outside this bank
  // a pin held high through reset gives one edge after reset, the detector starts low
  assign pinEdge = pinSync_r & ~pinLast_r;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pinMeta_r <= 1'b0;
      pinSync_r <= 1'b0;
      pinLast_r <= 1'b0;
    end
    else
    begin
      pinMeta_r <= extIntPin;
      pinSync_r <= pinMeta_r;
      pinLast_r <= pinSync_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // group merger sees the sub-source registers
  // the bank drives the interface nets directly, not through a modport
  genvar g;
  generate
    for (g = 0; g < 7; g++)
    begin : gSub
      assign grpBus.subPend[g] = sub_r[g][pib_pkg::PEND_LSB +: pib_pkg::SUB_W];
      assign grpBus.subAllow[g] = sub_r[g][pib_pkg::ALLOW_LSB +: pib_pkg::SUB_W];
    end
  endgenerate

  pib_group_merge uMerge
  (
    .grp(grpBus.merge)
  );

  ////////////////////////////////////////////////////////////////////////////
  // hardware set bits for each primary register
  // group flags follow the merged request level, so they cannot be
  // cleared while a sub flag still asks; clear the sub flag first
  always_comb
  begin
    setA = 8'h00;
    setB = 8'h00;
    setC = 8'h00;
    setA[pib_pkg::CA_CMP_PEND] = cmpEvt;
    setA[pib_pkg::CA_PIN_PEND] = pinEdge;
    setA[pib_pkg::CA_GRP0_PEND] = grpBus.grpReq[0];
    setB[pib_pkg::CB_OCP_PEND] = ocpEvt;
    setB[pib_pkg::CB_LVD_PEND] = lvdEvt;
    setB[pib_pkg::CB_NF_PEND] = nfEvt;
    setB[pib_pkg::CB_GRP1_PEND] = grpBus.grpReq[1];
    setC[pib_pkg::CC_GRP2_PEND] = grpBus.grpReq[2];
    setC[pib_pkg::CC_GRP3_PEND] = grpBus.grpReq[3];
    setC[pib_pkg::CC_GRP4_PEND] = grpBus.grpReq[4];
    setC[pib_pkg::CC_GRP5_PEND] = grpBus.grpReq[5];
  end

  ////////////////////////////////////////////////////////////////////////////
  // core request: flag and its allow, gated by the global allow
  always_comb
  begin
    // ctrl_a holds only three sources, so its pairs start one bit up
    reqA = |(ctrlA_r[pib_pkg::CA_PEND_LSB +: 3] & ctrlA_r[pib_pkg::CA_ALLOW_LSB +: 3]);
    reqB = |(ctrlB_r[pib_pkg::PEND_LSB +: 4] & ctrlB_r[pib_pkg::ALLOW_LSB +: 4]);
    reqC = |(ctrlC_r[pib_pkg::PEND_LSB +: 4] & ctrlC_r[pib_pkg::ALLOW_LSB +: 4]);
    coreReq = ctrlA_r[pib_pkg::CA_GLOBAL_ALLOW] & (reqA | reqB | reqC);
  end

  ////////////////////////////////////////////////////////////////////////////
  // next values of all software registers
  always_comb
  begin
    ctrlA_nxt = flagUpd(ctrlA_r, regWr & regHit(regAddr, pib_pkg::OFS_CTRL_A),
      regWdata, setA, pib_pkg::CTRL_A_IMPL);
    ctrlB_nxt = flagUpd(ctrlB_r, regWr & regHit(regAddr, pib_pkg::OFS_CTRL_B),
      regWdata, setB, pib_pkg::CTRL_B_IMPL);
    ctrlC_nxt = flagUpd(ctrlC_r, regWr & regHit(regAddr, pib_pkg::OFS_CTRL_C),
      regWdata, setC, pib_pkg::CTRL_C_IMPL);
    // an event on an already pending flag is worth telling software about
    // group flags are set every cycle their request stands, so they are
    // left out; a held group request must not read as overrun
    overrun = (|(setA & ctrlA_r & ~(8'h01 << pib_pkg::CA_GRP0_PEND))) |
      (|(setB & ctrlB_r & ~(8'h01 << pib_pkg::CB_GRP1_PEND)));
    for (int i = 0; i < 7; i++)
    begin
      sub_nxt[i] = flagUpd(sub_r[i],
        regWr & regHit(regAddr, pib_pkg::OFS_SUB_BASE + 4'(i)), regWdata,
        {subEvt[i * 4 +: 4], 4'h0}, pib_pkg::SUB_IMPL[i]);
      if ((|({subEvt[i * 4 +: 4], 4'h0} & sub_r[i])))
      begin
        overrun = 1'b1;
      end
    end
    // status: write one clears, a new event in the same cycle still lands
    // pin-edge and overrun bits are for polling; mask them off if unwanted
    stat_nxt = stat_r;
    if (regWr && regHit(regAddr, pib_pkg::OFS_STAT))
    begin
      stat_nxt = stat_r & ~regWdata;
    end
    stat_nxt[pib_pkg::ST_CORE_RISE] = stat_nxt[pib_pkg::ST_CORE_RISE] |
      (coreReq & ~coreIrq_r);
    stat_nxt[pib_pkg::ST_PIN_EDGE] = stat_nxt[pib_pkg::ST_PIN_EDGE] | pinEdge;
    stat_nxt[pib_pkg::ST_OVERRUN] = stat_nxt[pib_pkg::ST_OVERRUN] | overrun;
    stat_nxt = stat_nxt & pib_pkg::ST_IMPL;
    mask_nxt = mask_r;
    if (regWr && regHit(regAddr, pib_pkg::OFS_MASK))
    begin
      mask_nxt = regWdata & pib_pkg::ST_IMPL;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read decode; data stands only in the cycle after the strobe
  // unmapped addresses read as zero
  // reads have no side effects; a status read does not clear it
  always_comb
  begin
    rdata_nxt = 8'h00;
    if (regRd)
    begin
      if (regHit(regAddr, pib_pkg::OFS_CTRL_A))
      begin
        rdata_nxt = ctrlA_r;
      end
      else if (regHit(regAddr, pib_pkg::OFS_CTRL_B))
      begin
        rdata_nxt = ctrlB_r;
      end
      else if (regHit(regAddr, pib_pkg::OFS_CTRL_C))
      begin
        rdata_nxt = ctrlC_r;
      end
      else if (regHit(regAddr, pib_pkg::OFS_STAT))
      begin
        rdata_nxt = stat_r;
      end
      else if (regHit(regAddr, pib_pkg::OFS_MASK))
      begin
        rdata_nxt = mask_r;
      end
      else if (regAddr >= pib_pkg::OFS_SUB_BASE && regAddr < pib_pkg::OFS_STAT)
      begin
        rdata_nxt = sub_r[3'(regAddr - pib_pkg::OFS_SUB_BASE)];
      end
      else
      begin
        rdata_nxt = 8'h00;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register stage for everything above
  // every software register clears together; no bit survives reset
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ctrlA_r <= pib_pkg::CTRL_RST;
      ctrlB_r <= pib_pkg::CTRL_RST;
      ctrlC_r <= pib_pkg::CTRL_RST;
      for (int i = 0; i < 7; i++)
      begin
        sub_r[i] <= pib_pkg::SUB_RST;
      end
      stat_r <= pib_pkg::STAT_RST;
      mask_r <= pib_pkg::MASK_RST;
      rdata_r <= 8'h00;
      coreIrq_r <= 1'b0;
      irqOut_r <= 1'b0;
      grpSix_r <= 1'b0;
    end
    else
    begin
      ctrlA_r <= ctrlA_nxt;
      ctrlB_r <= ctrlB_nxt;
      ctrlC_r <= ctrlC_nxt;
      sub_r <= sub_nxt;
      stat_r <= stat_nxt;
      mask_r <= mask_nxt;
      rdata_r <= rdata_nxt;
      coreIrq_r <= coreReq;
      // level interrupt: from next status and mask, so in step with them
      irqOut_r <= |(stat_nxt & mask_nxt);
      grpSix_r <= grpBus.grpReq[6];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs all from flops
  assign regRdata = rdata_r;
  assign coreIrq = coreIrq_r;   // registered core request
  assign irqOut = irqOut_r;
  assign groupSixReq = grpSix_r; // group six flag lives elsewhere

endmodule

// File: tb/pib_flag_bank_chk.sv
// port assertions for the interrupt flag bank
// assumes one clock domain and a synchronous reset
`timescale 1ns/1ps
module pib_flag_bank_chk
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [7:0] regRdata,
  input wire logic cmpEvt,
  input wire logic coreIrq,
  input wire logic groupSixReq,
  input wire logic irqOut
);
  logic [1:0] allow_r;
  logic [1:0] allow_nxt;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////
  // shadow of cmp and global allow; events never move these
  always_comb
  begin
    allow_nxt = allow_r;
    if (regWr && regAddr == pib_pkg::OFS_CTRL_A)
    begin
      allow_nxt = {regWdata[pib_pkg::CA_CMP_ALLOW], regWdata[pib_pkg::CA_GLOBAL_ALLOW]};
    end
  end
  always_ff @(posedge clk)
  begin
    allow_r <= rst ? 2'h0 : allow_nxt;
  end
  ////////////////////////////////////////
  // read port and register layout
  property p_rd_idle;
    !$past(regRd) |-> regRdata == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("stray read data");
  property p_unmapped;
    regRd && regAddr >= 4'hC |=> regRdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read");
  property p_a_top;
    regRd && regAddr == 4'h0 |=> !regRdata[7];
  endproperty
  a_a_top: assert property (p_a_top) else $error("ctrl a bit 7 set");
  property p_sub_impl;
    regRd && regAddr >= 4'h6 && regAddr <= 4'h9 |=> (regRdata & 8'hCC) == 8'h00;
  endproperty
  a_sub_impl: assert property (p_sub_impl) else $error("sub reg spare bits");
  property p_c_allow;
    regWr && regAddr == 4'h2 ##1 regRd && regAddr == 4'h2
      |=> regRdata[3:0] == $past(regWdata[3:0], 2);
  endproperty
  a_c_allow: assert property (p_c_allow) else $error("ctrl c allows lost");
  // core request gating, and all three outputs low after reset
  property p_glob_off;
    !allow_r[0] |=> !coreIrq;
  endproperty
  a_glob_off: assert property (p_glob_off) else $error("irq without global");
  property p_cmp_irq;
    cmpEvt ##1 allow_r == 2'h3 |=> coreIrq;
  endproperty
  a_cmp_irq: assert property (p_cmp_irq) else $error("cmp irq missing");
  property p_irq_rst;
    disable iff (1'b0) rst |=> !coreIrq && !irqOut && !groupSixReq;
  endproperty
  a_irq_rst: assert property (p_irq_rst) else $error("outputs up in reset");
endmodule

// File: tb/pib_src_model.sv
// on-chip event sources and the external pin
// assumes the bench raises req for one cycle
`timescale 1ns/1ps
module pib_src_model
(
  input wire logic clk,
  input wire logic [32:0] req,
  output logic [31:0] evt,
  output logic pin
);
  logic [2:0] hold;
  initial
  begin
    evt = 32'h0000_0000;
    hold = 3'h0;
  end
  // one-cycle pulses; pin held 4 cycles so the synchroniser catches it
  always @(posedge clk)
  begin
    evt <= req[31:0];
    hold <= req[32] ? 3'h4 : hold - {2'h0, hold != 3'h0};
  end
  assign pin = hold != 3'h0;
endmodule

// File: tb/primary_irq_enable_flag_bank_tb_top.sv
// self-checking bench for the interrupt flag bank
// assumes the source model and checker beside it
`timescale 1ns/1ps
module primary_irq_enable_flag_bank_tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] regAddr = 4'h0;
  logic [7:0] regWdata = 8'h00;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [32:0] srcReq = '0;
  logic [7:0] regRdata;
  logic [31:0] evt;
  logic pin;
  logic coreIrq;
  logic groupSixReq;
  logic irqOut;
  logic rdSeen = 1'b0;
  logic [7:0] expQ[$];
  logic [7:0] x;
  logic [7:0] d;
  logic [7:0] cExp;
  int fail_count = 0;
  int n_compared = 0;
  int seed = 32'hb06a;

  initial
  begin
    forever #25 clk = ~clk;
  end

  pib_src_model pib_src_model_inst (.clk(clk), .req(srcReq), .evt(evt), .pin(pin));
  pib_flag_bank pib_flag_bank_inst (.clk(clk), .rst(rst), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .extIntPin(pin),
    .cmpEvt(evt[28]), .nfEvt(evt[29]), .lvdEvt(evt[30]), .ocpEvt(evt[31]),
    .subEvt(evt[27:0]), .coreIrq(coreIrq), .groupSixReq(groupSixReq), .irqOut(irqOut));

  ////////////////////////////////////////
  // one bus or event cycle; every strobe set each call, so back to back is safe
  task automatic op(input logic w, input logic r, input logic [3:0] a, input logic [7:0] v,
    input logic [32:0] q);
    regWr <= w;
    regRd <= r;
    regAddr <= a;
    regWdata <= v;
    srcReq <= q;
    @(posedge clk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v); op(1'b1, 1'b0, a, v, '0); endtask
  task automatic fire(input logic [32:0] q); op(1'b0, 1'b0, 4'h0, 8'h00, q); endtask
  task automatic idle(input int n); repeat (n) fire('0); endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    expQ.push_back(e);
    op(1'b0, 1'b1, a, 8'h00, '0);
  endtask
  // levels checked after the edge's updates land
  task automatic lvl(input logic [1:0] e);
    #1;
    n_compared++;
    if ({coreIrq, irqOut} !== e)
    begin
      $display("BAD %0t irq levels %b%b", $time, coreIrq, irqOut);
      fail_count++;
    end
    @(posedge clk);
  endtask
  task automatic six(input logic e);
    #1;
    n_compared++;
    if (groupSixReq !== e)
    begin
      $display("BAD %0t group six request %b", $time, groupSixReq);
      fail_count++;
    end
    @(posedge clk);
  endtask
  task automatic clr();
    for (int i = 11; i >= 0; i--)
      wr(i[3:0], (i == 10) ? 8'hFF : 8'h00);
  endtask
  function automatic logic [7:0] impl(input int i);
    case (i)
      0: return pib_pkg::CTRL_A_IMPL;
      1: return pib_pkg::CTRL_B_IMPL;
      2: return pib_pkg::CTRL_C_IMPL;
      11: return pib_pkg::ST_IMPL;
      12: return 8'h00;
      default: return pib_pkg::SUB_IMPL[i - 3];
    endcase
  endfunction
  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // read monitor: oldest note against data standing after the strobe
  always @(posedge clk)
  begin
    rdSeen <= regRd;
    if (rdSeen)
    begin
      x = expQ.pop_front();
      n_compared++;
      if (regRdata !== x)
      begin
        $display("BAD %0t read %h want %h", $time, regRdata, x);
        fail_count++;
      end
    end
  end

  initial
  begin
    repeat (5000) @(posedge clk);
    fail_count++;
    complete_run();
  end

  initial
  begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    idle(1);
    for (int i = 0; i < 16; i++)
      rd(i[3:0], 8'h00);
    $display("reset values done");
    for (int i = 0; i < 13; i++)
    begin
      d = $random(seed);
      wr(i[3:0], d);
      if (i != 10)
        rd(i[3:0], d & impl(i));
    end
    clr();
    $display("readback done");
    cExp = 8'h00;
    fire(33'h0_0000_0100);
    idle(4);
    rd(4'h2, 8'h00);
    for (int g = 1; g < 6; g++)
    begin
      wr(4'(3 + g), 8'h01);
      fire(33'h1 << (4 * g));
      idle(4);
      if (g > 1)
        cExp = cExp | (8'h01 << (g + 2));
      rd((g == 1) ? 4'h1 : 4'h2, (g == 1) ? 8'h20 : cExp);
    end
    wr(4'h0, 8'h01);
    wr(4'h2, cExp | 8'h08);
    idle(2);
    lvl(2'b10);
    wr(4'h2, cExp);
    idle(2);
    lvl(2'b00);
    wr(4'h9, 8'h01);
    fire(33'h1 << 24);
    idle(3);
    six(1'b1);
    wr(4'h9, 8'h00);
    idle(2);
    six(1'b0);
    clr();
    $display("group flags done");
    fire(33'h1_F000_0000);
    idle(6);
    rd(4'h0, 8'h60);
    rd(4'h1, 8'hD0);
    rd(4'hA, 8'h02);
    wr(4'h0, 8'h68);
    idle(3);
    lvl(2'b00);
    wr(4'h0, 8'h69);
    idle(2);
    lvl(2'b10);
    fire(33'h0_1000_0000);
    wr(4'hB, 8'h01);
    idle(1);
    lvl(2'b11);
    rd(4'hA, 8'h07);
    wr(4'hA, 8'h07);
    idle(1);
    lvl(2'b10);
    wr(4'h0, 8'h09);
    idle(2);
    lvl(2'b00);
    $display("events and irq done");
    idle(2);
    complete_run();
  end
endmodule

bind pib_flag_bank pib_flag_bank_chk pib_flag_bank_chk_inst (.clk(clk), .rst(rst),
  .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
  .cmpEvt(cmpEvt), .coreIrq(coreIrq), .groupSixReq(groupSixReq), .irqOut(irqOut));
